// [design/eeprom_pkg.sv]
// constants, state encoding and select code of the serial eeprom engine
// assumes one 20 MHz clock; bus pins sampled as synchronous inputs
//
// Summary of operation
// R1: match select byte, else stay silent
// R2: acknowledge select and both address bytes
// R3: program only on stop after data acknowledge
// R4: counter points past last modified byte
// R5: busy programming: release data, ignore everything
// R6: protected single byte gets no acknowledge
// R7: page write holds one to 32 bytes
// R8: page overflow wraps to page start
// R9: protected page: nack every data byte
// R10: in-page counter advances each acknowledged array data byte
// R11: top address bit set selects guard register
// R12: protect_enable turns block protection on
// R13: protect_size picks quarter, half, three quarters, all
// R14: protect_lock freezes the four guard bits
// R15: guard update only from single byte write
// R16: select is refused until programming ends
// R17: reads ignore protection, counter then advances
// R18: master nack ends read, device releases
// R19: random read: dummy write then read select
// R20: current read uses internal address counter
// R21: sequential read wraps from top to zero
// R22: guard reads upper nibble zero, repeats value
// R23: array erased to ones, guard cleared
// R24: protection compares top array address bits
package eeprom_pkg;
	localparam int         addr_w         = 13;
	localparam int         mem_bytes      = 8192;
	localparam int         off_w          = 5;
	localparam int         page_bytes     = 32;
	localparam int         base_w         = 8;
	// arbitrary value: seven upper bits of the select byte
	localparam logic [6:0] select_code    = 7'h2B;
	localparam int         prog_time_us   = 5000;
	localparam int         clk_mhz        = 20;
	localparam int         prog_cycles_df = prog_time_us * clk_mhz;
	localparam logic [7:0] mem_erased     = 8'hFF;
	localparam logic [3:0] guard_reset    = 4'h0;
	localparam int         enable_bit     = 3;
	localparam int         size_hi        = 2;
	localparam int         size_lo        = 1;
	localparam int         lock_bit       = 0;
	localparam int         reg_sel_bit    = 7;
	localparam logic [3:0] last_bit       = 4'h7;
	localparam logic [3:0] ack_slot       = 4'h8;
	// the stop's own scl pulse is the single rise after a data ack
	localparam logic [3:0] stop_slot      = 4'h1;
	localparam logic [1:0] size_quarter   = 2'h0;
	localparam logic [1:0] size_half      = 2'h1;
	localparam logic [1:0] size_three_q   = 2'h2;
	typedef enum logic [2:0] {
		st_idle   = 3'b000,
		st_dev    = 3'b001,
		st_adr_hi = 3'b011,
		st_adr_lo = 3'b010,
		st_wdata  = 3'b110,
		st_rdata  = 3'b101
	} state_t;
endpackage : eeprom_pkg

// [design/word_buffer.sv]
// two-entry valid/ready buffer for incoming write bytes
// assumes one clock; source and sink follow valid/ready handshakes
`timescale 1ns/100ps
module word_buffer #(
	parameter int width = 13,
	parameter int depth = 2
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [width-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [width-1:0] out_data
);
	localparam int pw = (depth > 1) ? $clog2(depth) : 1;
	localparam logic [pw:0] full = (pw + 1)'(depth);

	logic [width-1:0] slot [depth];
	logic [pw-1:0]    wr_ptr;
	logic [pw-1:0]    rd_ptr;
	logic [pw:0]      count;
	logic             push;
	logic             pop;

	assign in_ready  = (count != full);
	assign out_valid = (count != '0);
	assign out_data  = slot[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			slot[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == pw'(depth - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == pw'(depth - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (pw + 1)'(push) - (pw + 1)'(pop);
		end
	end
endmodule : word_buffer

// [design/eeprom_engine.sv]
// two-wire serial eeprom slave: select, address, page write, reads,
// write guard register and timed programming cycle
// assumes scl and sda_in synchronous to clk and far slower than it
`timescale 1ns/100ps
module eeprom_engine #(
	parameter int prog_cycles = eeprom_pkg::prog_cycles_df
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic scl,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe_n
);
	localparam int cnt_w = $clog2(prog_cycles + 1);
	localparam int bw    = eeprom_pkg::off_w + 8;

	logic [7:0]                    mem [eeprom_pkg::mem_bytes];
	logic [7:0]                    page_data [eeprom_pkg::page_bytes];
	logic [eeprom_pkg::page_bytes-1:0] page_valid;
	eeprom_pkg::state_t            state;
	logic                          scl_q;
	logic                          sda_q;
	logic                          scl_rise;
	logic                          scl_fall;
	logic                          start_c;
	logic                          stop_c;
	logic [3:0]                    bit_cnt;
	logic [7:0]                    shreg;
	logic [7:0]                    byte_in;
	logic                          byte_done;
	logic                          ack_slot_rise;
	logic                          rd_slot;
	logic                          ack_now;
	logic                          next_ack;
	logic [eeprom_pkg::addr_w-1:0] addr;
	logic                          reg_sel;
	logic [3:0]                    guard;
	logic [3:0]                    reg_pend;
	logic [1:0]                    wcount;
	logic                          stored;
	logic [eeprom_pkg::off_w-1:0]  last_off;
	logic [7:0]                    tx_byte;
	logic                          is_protected;
	logic                          match;
	logic                          busy;
	logic                          prog_req;
	logic                          prog_reg;
	logic                          prog_fire;
	logic [eeprom_pkg::base_w-1:0] prog_base;
	logic [cnt_w-1:0]              prog_cnt;
	logic                          prog_done;
	logic [eeprom_pkg::off_w-1:0]  prog_idx;
	logic                          buf_in_valid;
	logic                          buf_in_ready;
	logic                          buf_out_valid;
	logic                          buf_out_ready;
	logic [bw-1:0]                 buf_out_data;
	logic [eeprom_pkg::addr_w-1:0] after_last;
	logic [eeprom_pkg::addr_w-1:0] next_rd_addr;

	// factory state of the array
	initial begin
		for (int i = 0; i < eeprom_pkg::mem_bytes; i++) begin
			mem[i] = eeprom_pkg::mem_erased; // [R23]
		end
	end

	////////////////////////////////////////////////////////////////////
	// bus condition detection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda_in;
		end
	end

	assign scl_rise      = scl && !scl_q;
	assign scl_fall      = !scl && scl_q;
	// conditions are ignored while programming runs
	assign start_c       = !busy && scl && scl_q && sda_q && !sda_in;
	assign stop_c        = !busy && scl && scl_q && !sda_q && sda_in;
	assign byte_in       = {shreg[6:0], sda_in};
	assign byte_done     = !busy && scl_rise && (bit_cnt == eeprom_pkg::last_bit);
	assign ack_slot_rise = !busy && scl_rise && (bit_cnt == eeprom_pkg::ack_slot);
	// the select's own ack slot must not step the read counter
	assign rd_slot       = ack_slot_rise && state == eeprom_pkg::st_rdata &&
		!ack_now;
	assign sda_out       = 1'b0;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bit_cnt <= '0;
			shreg   <= '0;
		end else if (start_c || busy) begin
			bit_cnt <= '0;
		end else if (scl_rise) begin
			shreg   <= byte_in;
			bit_cnt <= (bit_cnt == eeprom_pkg::ack_slot) ? '0 : bit_cnt + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// protection decision on the top array address bits
	always_comb begin
		is_protected = 1'b0;
		if (guard[eeprom_pkg::enable_bit]) begin // [R12]
			case (guard[eeprom_pkg::size_hi:eeprom_pkg::size_lo]) // [R13]
				eeprom_pkg::size_quarter: is_protected = &addr[12:11]; // [R24]
				eeprom_pkg::size_half:    is_protected = addr[12];
				eeprom_pkg::size_three_q: is_protected = |addr[12:11];
				default:                  is_protected = 1'b1;
			endcase
		end
	end

	assign match = (byte_in[7:1] == eeprom_pkg::select_code); // [R1]

	always_comb begin
		case (state)
			eeprom_pkg::st_dev:    next_ack = match; // [R1] [R16]
			eeprom_pkg::st_adr_hi: next_ack = 1'b1; // [R2]
			eeprom_pkg::st_adr_lo: next_ack = 1'b1; // [R2]
			// a full buffer refuses the byte rather than lose it
			eeprom_pkg::st_wdata:  next_ack = reg_sel ||
				(!is_protected && buf_in_ready); // [R6] [R9]
			default:               next_ack = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// instruction state machine
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= eeprom_pkg::st_idle;
		end else if (busy || stop_c) begin
			state <= eeprom_pkg::st_idle; // [R5]
		end else if (start_c) begin
			state <= eeprom_pkg::st_dev;
		end else if (byte_done) begin
			case (state)
				eeprom_pkg::st_dev: begin
					if (!match) begin
						state <= eeprom_pkg::st_idle; // [R1]
					end else if (byte_in[0]) begin
						state <= eeprom_pkg::st_rdata; // [R20]
					end else begin
						state <= eeprom_pkg::st_adr_hi; // [R2]
					end
				end
				eeprom_pkg::st_adr_hi: state <= eeprom_pkg::st_adr_lo;
				eeprom_pkg::st_adr_lo: state <= eeprom_pkg::st_wdata; // [R19]
				default:               state <= state;
			endcase
		end else if (rd_slot && sda_in) begin
			state <= eeprom_pkg::st_idle; // [R18]
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_now <= 1'b0;
		end else if (busy || start_c || stop_c || ack_slot_rise) begin
			ack_now <= 1'b0;
		end else if (byte_done) begin
			ack_now <= next_ack;
		end
	end

	// open drain: enable low only while pulling the line low
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sda_oe_n <= 1'b1;
		end else if (busy || start_c || stop_c) begin
			sda_oe_n <= 1'b1; // [R5]
		end else if (scl_fall) begin
			if (ack_now) begin
				sda_oe_n <= 1'b0;
			end else if (state == eeprom_pkg::st_rdata &&
					bit_cnt < eeprom_pkg::ack_slot) begin
				sda_oe_n <= tx_byte[3'(eeprom_pkg::last_bit - bit_cnt)];
			end else begin
				sda_oe_n <= 1'b1; // [R18]
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// address counter, register select and write bookkeeping
	assign after_last   = {prog_base, last_off} + 1'b1;
	assign next_rd_addr = addr + 1'b1; // [R21]

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addr     <= '0;
			reg_sel  <= 1'b0;
			last_off <= '0;
		end else if (prog_done && !prog_reg) begin
			addr <= after_last; // [R4]
		end else if (byte_done && state == eeprom_pkg::st_adr_hi) begin
			reg_sel     <= byte_in[eeprom_pkg::reg_sel_bit]; // [R11]
			addr[12:8]  <= byte_in[4:0];
		end else if (byte_done && state == eeprom_pkg::st_adr_lo) begin
			addr[7:0] <= byte_in;
		end else if (buf_in_valid && buf_in_ready) begin
			last_off  <= addr[4:0];
			addr[4:0] <= addr[4:0] + 1'b1; // [R8] [R10]
		end else if (rd_slot && !reg_sel) begin
			addr <= next_rd_addr; // [R17]
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wcount   <= '0;
			stored   <= 1'b0;
			reg_pend <= '0;
		end else if (byte_done && state == eeprom_pkg::st_adr_lo) begin
			wcount <= '0;
			stored <= 1'b0;
		end else if (byte_done && state == eeprom_pkg::st_wdata) begin
			wcount <= (wcount == 2'h2) ? wcount : wcount + 1'b1;
			if (reg_sel) begin
				reg_pend <= byte_in[3:0]; // upper nibble is don't care
			end else if (buf_in_valid && buf_in_ready) begin
				stored <= 1'b1;
			end
		end
	end

	// read data: guard reads back zero-extended and repeats
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_byte <= '0;
		end else if (byte_done && state == eeprom_pkg::st_dev) begin
			tx_byte <= reg_sel ? {4'h0, guard} : mem[addr]; // [R20] [R22]
		end else if (rd_slot) begin
			tx_byte <= reg_sel ? {4'h0, guard} : mem[next_rd_addr]; // [R21]
		end
	end

	////////////////////////////////////////////////////////////////////
	// write byte buffer and page latch
	assign buf_in_valid  = byte_done && state == eeprom_pkg::st_wdata &&
		!reg_sel && !is_protected; // [R9]
	// drain stalls while programming so the latch stays frozen
	assign buf_out_ready = !busy;

	word_buffer #(
		.width (bw),
		.depth (2)
	) u_wbuf (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (buf_in_valid),
		.in_ready  (buf_in_ready),
		.in_data   ({addr[4:0], byte_in}),
		.out_valid (buf_out_valid),
		.out_ready (buf_out_ready),
		.out_data  (buf_out_data)
	);

	always_ff @(posedge clk) begin
		if (buf_out_valid && buf_out_ready) begin
			page_data[buf_out_data[bw-1:8]] <= buf_out_data[7:0]; // [R7]
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			page_valid <= '0;
		end else if (prog_done ||
				(byte_done && state == eeprom_pkg::st_adr_lo)) begin
			page_valid <= '0;
		end else if (buf_out_valid && buf_out_ready) begin
			page_valid[buf_out_data[bw-1:8]] <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// programming cycle
	assign prog_fire = stop_c && state == eeprom_pkg::st_wdata &&
		bit_cnt == eeprom_pkg::stop_slot &&
		(reg_sel ? wcount == 2'h1 : stored); // [R3] [R15]
	assign prog_done = busy && prog_cnt == cnt_w'(prog_cycles - 1);
	assign prog_idx  = prog_cnt[eeprom_pkg::off_w-1:0];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prog_req  <= 1'b0;
			prog_reg  <= 1'b0;
			busy      <= 1'b0;
			prog_cnt  <= '0;
			prog_base <= '0;
		end else if (prog_fire) begin
			prog_req  <= 1'b1;
			prog_reg  <= reg_sel;
			prog_base <= addr[12:5]; // [R7]
		end else if (prog_req && !buf_out_valid) begin
			prog_req <= 1'b0;
			busy     <= 1'b1; // [R5]
			prog_cnt <= '0;
		end else if (prog_done) begin
			busy <= 1'b0; // [R16]
		end else if (busy) begin
			prog_cnt <= prog_cnt + 1'b1;
		end
	end

	// one latched byte per cycle; all land well inside the cycle time
	always_ff @(posedge clk) begin
		if (busy && !prog_reg &&
				prog_cnt < cnt_w'(eeprom_pkg::page_bytes) &&
				page_valid[prog_idx]) begin
			mem[{prog_base, prog_idx}] <= page_data[prog_idx]; // [R7]
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			guard <= eeprom_pkg::guard_reset; // [R23]
		end else if (prog_done && prog_reg &&
				!guard[eeprom_pkg::lock_bit]) begin
			guard <= reg_pend; // [R14] [R15]
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	property p_select_miss;
		@(posedge clk) disable iff (!resetn)
		(byte_done && state == eeprom_pkg::st_dev && !match) |=>
			!ack_now && state == eeprom_pkg::st_idle;
	endproperty
	a_select_miss: assert property (p_select_miss) // [R1]
		else $error("unmatched select was acknowledged");

	property p_busy_quiet;
		@(posedge clk) disable iff (!resetn)
		busy |-> sda_oe_n && state == eeprom_pkg::st_idle;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) // [R5]
		else $error("device active during programming");

	property p_stop_slot;
		@(posedge clk) disable iff (!resetn)
		(stop_c && state == eeprom_pkg::st_wdata && !prog_req && !busy &&
			(bit_cnt != eeprom_pkg::stop_slot || (!reg_sel && !stored)))
			|=> !prog_req;
	endproperty
	a_stop_slot: assert property (p_stop_slot) // [R3]
		else $error("stop outside tenth slot started programming");

	property p_counter_after;
		@(posedge clk) disable iff (!resetn)
		($fell(busy) && !prog_reg) |-> addr == $past(after_last);
	endproperty
	a_counter_after: assert property (p_counter_after) // [R4]
		else $error("counter not past last modified byte");

	property p_protect_nack;
		@(posedge clk) disable iff (!resetn)
		(byte_done && state == eeprom_pkg::st_wdata && !reg_sel &&
			is_protected) |=> !ack_now && !buf_out_valid;
	endproperty
	a_protect_nack: assert property (p_protect_nack) // [R9]
		else $error("protected data byte acknowledged");

	property p_lock_hold;
		@(posedge clk) disable iff (!resetn)
		guard[eeprom_pkg::lock_bit] |=> guard == $past(guard);
	endproperty
	a_lock_hold: assert property (p_lock_hold) // [R14]
		else $error("locked guard changed");

	property p_read_step;
		@(posedge clk) disable iff (!resetn)
		(rd_slot && !reg_sel && !prog_done) |=>
			addr == $past(addr) + 13'h1;
	endproperty
	a_read_step: assert property (p_read_step) // [R17]
		else $error("read did not advance counter");

	property p_master_nack;
		@(posedge clk) disable iff (!resetn)
		(rd_slot && sda_in && !stop_c) |=>
			state == eeprom_pkg::st_idle && sda_oe_n;
	endproperty
	a_master_nack: assert property (p_master_nack) // [R18]
		else $error("read kept going after master nack");

	property p_guard_read;
		@(posedge clk) disable iff (!resetn)
		(state == eeprom_pkg::st_rdata && reg_sel) |-> tx_byte[7:4] == 4'h0;
	endproperty
	a_guard_read: assert property (p_guard_read) // [R22]
		else $error("guard upper nibble not zero");

	c_program: cover property (@(posedge clk) disable iff (!resetn)
		$rose(busy) && !prog_reg);
	c_guard_write: cover property (@(posedge clk) disable iff (!resetn)
		prog_done && prog_reg);
	c_seq_read: cover property (@(posedge clk) disable iff (!resetn)
		rd_slot && !sda_in);
endmodule : eeprom_engine

// [bench/bus_master.sv]
// two-wire bus master model: start, stop, byte out, byte in
// assumes the bench resolves the data wire and calls these tasks
`timescale 1ns/100ps
module bus_master (
	input  wire logic clk,
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda_m
);
	////////////////////////////////////////////////////////////////////
	initial begin
		scl   = 1'b1;
		sda_m = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// data moves one clk after scl falls so no edge looks like a stop
	task automatic bit_io(input logic b, output logic r);
		tick(1);
		sda_m <= b;
		tick(3);
		scl <= 1'b1;
		tick(2);
		#1 r = sda_wire;
		tick(2);
		scl <= 1'b0;
	endtask : bit_io

	task automatic start;
		sda_m <= 1'b1;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sda_m <= 1'b0;
		tick(4);
		scl <= 1'b0;
	endtask : start

	task automatic stop;
		tick(1);
		sda_m <= 1'b0;
		tick(3);
		scl <= 1'b1;
		tick(4);
		sda_m <= 1'b1;
		tick(4);
	endtask : stop

	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask : send

	// more=1 acknowledges the byte and asks for the next one
	task automatic recv(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~more, r);
	endtask : recv
endmodule : bus_master

// [bench/testbench.sv]
// self-checking bench of the serial eeprom engine
// assumes the bus master model drives scl and the master data level
`timescale 1ns/100ps
module testbench;
	localparam int busy_clks = 400;
	typedef struct packed {
		logic [15:0] a;
		logic [7:0]  d;
		logic        k;
		logic [7:0]  q;
	} row_t;
	logic clk;
	logic resetn;
	logic scl;
	logic sda_m;
	logic sda_oe_n;
	logic sda_out;
	wire  sda_wire = sda_oe_n ? sda_m : sda_out;
	int   error_cnt;
	int   cmp_count;
	int   n;
	logic k;
	row_t rows [0:17] = '{
		{16'h0000, 8'h5A, 1'b1, 8'h5A}, {16'h1FFF, 8'hA5, 1'b1, 8'hA5},
		{16'h8000, 8'hF8, 1'b1, 8'h08}, {16'h1800, 8'h11, 1'b0, 8'hFF},
		{16'h17FF, 8'h22, 1'b1, 8'h22}, {16'h8000, 8'hFA, 1'b1, 8'h0A},
		{16'h1000, 8'h33, 1'b0, 8'hFF}, {16'h0FFF, 8'h44, 1'b1, 8'h44},
		{16'h8000, 8'hFC, 1'b1, 8'h0C}, {16'h0800, 8'h55, 1'b0, 8'hFF},
		{16'h07FF, 8'h66, 1'b1, 8'h66}, {16'h8000, 8'hFE, 1'b1, 8'h0E},
		{16'h0000, 8'h77, 1'b0, 8'h5A}, {16'hF123, 8'hF0, 1'b1, 8'h00},
		{16'h1800, 8'h88, 1'b1, 8'h88}, {16'h8000, 8'h01, 1'b1, 8'h01},
		{16'h8000, 8'h0E, 1'b1, 8'h01}, {16'h0000, 8'h99, 1'b1, 8'h99}
	};

	////////////////////////////////////////////////////////////////////
	always #25 clk = ~clk;

	bus_master m_u (.clk(clk), .sda_wire(sda_wire), .scl(scl),
		.sda_m(sda_m));

	eeprom_engine #(.prog_cycles(busy_clks)) dut_u (.clk(clk),
		.resetn(resetn), .scl(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n));

	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic addr_ph(input logic [15:0] a);
		logic ak;
		m_u.start();
		m_u.send({eeprom_pkg::select_code, 1'b0}, ak);
		check(ak, 1'b1);
		m_u.send(a[15:8], ak);
		check(ak, 1'b1);
		m_u.send(a[7:0], ak);
		check(ak, 1'b1);
	endtask : addr_ph

	// write-direction select repeated until acknowledged, bounded
	task automatic poll(output int cnt);
		logic ak;
		cnt = 0;
		ak = 1'b0;
		while (ak !== 1'b1 && cnt < 20) begin
			m_u.start();
			m_u.send({eeprom_pkg::select_code, 1'b0}, ak);
			m_u.stop();
			cnt++;
		end
		check(ak, 1'b1);
	endtask : poll

	task automatic wr(input logic [15:0] a, input logic [7:0] d[$],
		input logic kx, output int cnt);
		logic ak;
		addr_ph(a);
		foreach (d[i]) begin
			m_u.send(d[i], ak);
			check(ak, kx);
		end
		m_u.stop();
		poll(cnt);
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic cur,
		input logic [7:0] q[$]);
		logic       ak;
		logic [7:0] v;
		if (!cur)
			addr_ph(a);
		m_u.start();
		m_u.send({eeprom_pkg::select_code, 1'b1}, ak);
		check(ak, 1'b1);
		foreach (q[i]) begin
			m_u.recv(i < q.size() - 1, v);
			check(v, q[i]);
		end
		m_u.tick(2);
		check(sda_oe_n, 1'b1);
		m_u.stop();
	endtask : rd

	task automatic results;
		$display("comparisons %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////
	// each row is far under 2000 clks; the whole run stays near 27000
	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		results();
	end

	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		m_u.tick(2);
		check(sda_oe_n, 1'b1);
		foreach (rows[i]) begin
			wr(rows[i].a, '{rows[i].d}, rows[i].k, n);
			rd(rows[i].a, 1'b0, '{rows[i].q});
		end
		// busy cycle refuses the first polls
		wr(16'h0020, '{8'hB0, 8'hB1}, 1'b1, n);
		check(n > 1, 1'b1);
		wr(16'h003E, '{8'hC0, 8'hC1, 8'hC2}, 1'b1, n);
		rd(16'h0000, 1'b1, '{8'hB1, 8'hFF});
		rd(16'h003E, 1'b0, '{8'hC0, 8'hC1, 8'hFF});
		rd(16'h0020, 1'b0, '{8'hC2});
		rd(16'h1FFF, 1'b0, '{8'hA5, 8'h99});
		rd(16'hF123, 1'b0, '{8'h01, 8'h01});
		// stop right after the address starts no cycle
		addr_ph(16'h0050);
		m_u.stop();
		poll(n);
		check(n == 1, 1'b1);
		// foreign select code is ignored
		m_u.start();
		m_u.send({eeprom_pkg::select_code ^ 7'h01, 1'b0}, k);
		check(k, 1'b0);
		m_u.send(8'h00, k);
		check(k, 1'b0);
		m_u.stop();
		// mid-run reset clears the locked guard
		resetn <= 1'b0;
		m_u.tick(2);
		check(sda_oe_n, 1'b1);
		resetn <= 1'b1;
		m_u.tick(2);
		rd(16'h8000, 1'b0, '{8'h00});
		// two data bytes to the guard discard the update
		addr_ph(16'h8000);
		m_u.send(8'h0F, k);
		m_u.send(8'h08, k);
		m_u.stop();
		poll(n);
		rd(16'h8000, 1'b0, '{8'h00});
		results();
	end
endmodule : testbench
